// File: src/phy_rst_pkg.sv
// constants, register map and carrier types for the reset/power-down sequencer
// assumes a single 125 MHz reference clock
package phy_rst_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int POR_HOLD_NS = 20000;
  localparam int POR_HOLD_CYC = POR_HOLD_NS / CLK_PERIOD_NS;
  localparam int MAC_RELEASE_MAX_NS = 640;
  localparam int MAC_RELEASE_MAX_CYC = MAC_RELEASE_MAX_NS / CLK_PERIOD_NS;
  localparam int EXIT_STEP_CYC = 16;
  localparam int EXIT_PIPE_CYC = 6;
  localparam int EXIT_DWELL_CYC = EXIT_STEP_CYC - EXIT_PIPE_CYC;
  localparam int SW_RESET_CYC = 2;
  localparam int HW_RST_MIN_CYC = 5;
  localparam int CLK_SETTLE_MS = 53;
  localparam int CLK_SETTLE_CYC = CLK_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TMR_W = 23;
  localparam int DIV_W = 4;
  localparam int DATA_W = 16;
  localparam int REG_ADDR_W = 5;
  localparam int ADDR_W = 5;
  localparam int PEAK_W = 8;
  localparam logic [REG_ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 5'h01;
  localparam logic [REG_ADDR_W-1:0] REG_EXT_CTRL = 5'h10;
  localparam int CTRL_SWRST_BIT = 15;
  localparam int CTRL_PD_BIT = 11;
  localparam int EXT_ADDR_LSB = 6;
  localparam int STAT_LH_BIT = 0;
  localparam int STAT_LL_BIT = 1;
  localparam int STAT_PEAK_LSB = 8;
  localparam logic LH_DEFAULT = 1'h0;
  localparam logic LL_DEFAULT = 1'h1;
  localparam logic [PEAK_W-1:0] PEAK_DEFAULT = 8'h00;

  typedef enum logic [2:0] {
    ST_POR, ST_HW, ST_SW, ST_EXIT, ST_SETTLE, ST_RUN
  } seq_state_t;

  typedef struct packed {
    logic [3:0] txd;
    logic tx_en;
    logic tx_er;
  } mac_tx_t;

  typedef struct packed {
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
  } mac_rx_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } line_t;
endpackage

// File: src/rst_pin_filter.sv
// synchroniser and minimum-width filter for the active-low hardware reset pin
// assumes the pin is asynchronous to ref_clk_i
`timescale 1ns/1ns
module rst_pin_filter
  import phy_rst_pkg::*;
#(
  parameter int MIN_CYC = HW_RST_MIN_CYC
)(
  input wire logic ref_clk_i, // reference clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic pin_n_i, // raw reset pin
  output logic pin_low_o, // synchronised pin is low
  output logic req_o // qualified reset request, level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [3:0] cnt;
    logic req;
  } filt_t;

  filt_t r;
  filt_t n;

  always_comb
  begin
    n = r;
    n.s1 = pin_n_i;
    n.s2 = r.s1;
    if (r.s2)
    begin
      n.cnt = '0;
      n.req = 1'b0;
    end
    else
    begin
      // short glitches never reach the count and are ignored
      if (r.cnt < 4'(MIN_CYC))
        n.cnt = r.cnt + 4'h1;
      if (r.cnt == 4'(MIN_CYC - 1))
        n.req = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '{s1: 1'b1, s2: 1'b1, cnt: 4'h0, req: 1'b0};
    else
      r <= n;
  end

  assign pin_low_o = !r.s2;
  assign req_o = r.req;
endmodule

// File: src/seq_timer.sv
// loadable down-counter; done stays high once the count reaches zero
// assumes the caller loads the count minus one
`timescale 1ns/1ns
module seq_timer
  import phy_rst_pkg::*;
#(
  parameter logic [TMR_W-1:0] INIT = TMR_W'(POR_HOLD_CYC - 1)
)(
  input wire logic ref_clk_i, // reference clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic load_i, // load pulse
  input wire logic [TMR_W-1:0] val_i, // value to load
  output logic done_o // count is zero
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
  } tmr_t;

  tmr_t r;
  tmr_t n;

  always_comb
  begin
    n = r;
    if (load_i)
      n.cnt = val_i;
    else if (r.cnt != '0)
      n.cnt = r.cnt - TMR_W'(1);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '{cnt: INIT};
    else
      r <= n;
  end

  assign done_o = (r.cnt == '0);
endmodule

// File: src/phy_reset_powerdown_seq.sv
// reset and power-down sequencer of a 10/100 transceiver: register port,
// MAC-side gating, line driver enables and clock-recovery hold-off
// assumes rst_n_i is the supply-good (power-on) reset, one 125 MHz clock
`timescale 1ns/1ns
module phy_reset_powerdown_seq
  import phy_rst_pkg::*;
#(
  parameter int SETTLE_CYC = CLK_SETTLE_CYC,
  parameter int CLK_HALF_CYC = 2
)(
  input wire logic ref_clk_i, // 125 MHz reference clock
  input wire logic rst_n_i, // power-on reset, async, active low
  input wire logic hw_reset_pin_n_i, // hardware reset pin, async
  input wire logic [ADDR_W-1:0] phy_addr_strap_i, // address straps, async
  input wire logic [REG_ADDR_W-1:0] reg_addr_i, // register address
  input wire logic [DATA_W-1:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [DATA_W-1:0] reg_rdata_o, // read data, cycle after strobe
  input wire mac_tx_t mac_tx_i, // MAC-side inputs from pins
  output mac_tx_t core_tx_o, // isolated MAC inputs to the core
  input wire mac_rx_t core_rx_i, // core data toward MAC
  output mac_rx_t mac_rx_o, // MAC-side outputs
  output logic transmit_clock_out_o, // transmit clock to MAC
  output logic receive_clock_out_o, // receive clock to MAC
  input wire line_t core_line_i, // line transmit levels from core
  output logic line_tx_positive_o, // line transmit positive
  output logic line_tx_negative_o, // line transmit negative
  output logic line_tx_oe_o, // line transmit enable, high drives
  input wire logic latch_high_event_i, // event for latch-high bit
  input wire logic latch_low_cond_i, // condition for latch-low bit
  input wire logic [PEAK_W-1:0] peak_sample_i, // sample for peak bits
  output logic core_reset_o, // holds internal modules at default
  output logic power_down_o, // power-down state
  output logic mgmt_ready_o, // management port accepts access
  output logic clocks_valid_o // MAC interface may be used while power_down_o is low
);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_HALF_CYC - 1);

  typedef struct packed {
    seq_state_t st;
    logic sw_exit;
    logic ctrl_swrst;
    logic ctrl_pd;
    logic [ADDR_W-1:0] strap_s1;
    logic [ADDR_W-1:0] strap_s2;
    logic [ADDR_W-1:0] phy_addr;
    logic latch_high_status_bit;
    logic latch_low_status_bit;
    logic [PEAK_W-1:0] latch_peak_status_bit;
    logic [DATA_W-1:0] rdata;
    mac_rx_t mac_rx;
    mac_tx_t core_tx;
    line_t line;
    logic line_oe;
    logic [DIV_W-1:0] div_cnt;
    logic mac_clk;
  } seq_regs_t;

  localparam seq_regs_t REGS_RESET = '{
    st: ST_POR,
    sw_exit: 1'b0,
    ctrl_swrst: 1'b0,
    ctrl_pd: 1'b0,
    strap_s1: '0,
    strap_s2: '0,
    phy_addr: '0,
    latch_high_status_bit: LH_DEFAULT,
    latch_low_status_bit: LL_DEFAULT,
    latch_peak_status_bit: PEAK_DEFAULT,
    rdata: '0,
    mac_rx: '0,
    core_tx: '0,
    line: '0,
    line_oe: 1'b0,
    div_cnt: '0,
    mac_clk: 1'b0
  };

  function automatic logic [TMR_W-1:0] cyc_load(input int cyc);
    cyc_load = TMR_W'(cyc - 1);
  endfunction

  seq_regs_t r;
  seq_regs_t n;
  logic pin_low;
  logic hw_req;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_done;
  logic in_reset;
  logic pd;
  logic released;
  logic mgmt_ready;
  logic wr_ctrl;
  logic sw_req;
  logic pd_set;
  logic stat_rd;

  rst_pin_filter #(
    .MIN_CYC(HW_RST_MIN_CYC)
  ) u_pin (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_n_i(hw_reset_pin_n_i),
    .pin_low_o(pin_low),
    .req_o(hw_req)
  );

  // timer comes out of power-on reset already counting the hold time
  seq_timer #(
    .INIT(cyc_load(POR_HOLD_CYC))
  ) u_tmr (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .val_i(tmr_val),
    .done_o(tmr_done)
  );

  assign in_reset = (r.st == ST_POR) || (r.st == ST_HW) ||
                    (r.st == ST_SW) || (r.st == ST_EXIT);
  // software reset never powers down; exit step leaves power-down
  assign pd = (r.st == ST_POR) || (r.st == ST_HW) || r.ctrl_pd ||
              (pin_low && (r.st != ST_POR));
  // MAC side and line stay off until both reset and power-down are gone
  assign released = !in_reset && !pd;
  assign mgmt_ready = (r.st == ST_SETTLE) || (r.st == ST_RUN);
  assign wr_ctrl = reg_wr_i && mgmt_ready && (reg_addr_i == REG_CTRL);
  assign sw_req = wr_ctrl && reg_wdata_i[CTRL_SWRST_BIT];
  assign pd_set = wr_ctrl && reg_wdata_i[CTRL_PD_BIT] && !r.ctrl_pd;
  assign stat_rd = reg_rd_i && mgmt_ready && (reg_addr_i == REG_STATUS);

  always_comb
  begin
    n = r;
    tmr_load = 1'b0;
    tmr_val = '0;
    n.strap_s1 = phy_addr_strap_i;
    n.strap_s2 = r.strap_s1;

    unique case (r.st)
      ST_POR:
      begin
        // the pin is not looked at until the hold time has run out
        if (tmr_done)
        begin
          n.st = ST_EXIT;
          n.sw_exit = 1'b0;
          tmr_load = 1'b1;
          tmr_val = cyc_load(EXIT_DWELL_CYC);
        end
      end
      ST_HW:
      begin
        if (!hw_req)
        begin
          n.st = ST_EXIT;
          n.sw_exit = 1'b0;
          tmr_load = 1'b1;
          tmr_val = cyc_load(EXIT_DWELL_CYC);
        end
      end
      ST_SW:
      begin
        // a pin reset overrides a software reset in progress
        if (hw_req)
          n.st = ST_HW;
        else if (tmr_done)
        begin
          n.st = ST_EXIT;
          n.sw_exit = 1'b1;
          tmr_load = 1'b1;
          tmr_val = cyc_load(EXIT_DWELL_CYC);
        end
      end
      ST_EXIT:
      begin
        if (hw_req)
          n.st = ST_HW;
        else if (tmr_done)
        begin
          n.st = ST_SETTLE;
          tmr_load = 1'b1;
          tmr_val = cyc_load(SETTLE_CYC);
        end
      end
      ST_SETTLE, ST_RUN:
      begin
        if (hw_req)
          n.st = ST_HW;
        else if (sw_req)
        begin
          n.st = ST_SW;
          tmr_load = 1'b1;
          tmr_val = cyc_load(SW_RESET_CYC);
        end
        else if ((r.st == ST_SETTLE) && tmr_done)
          n.st = ST_RUN;
      end
    endcase

    // register file
    if (in_reset)
    begin
      // everything but the reset bit back to default; the address is kept for later capture
      n.ctrl_pd = 1'b0;
      n.ctrl_swrst = (r.st == ST_SW) || ((r.st == ST_EXIT) && r.sw_exit);
      n.latch_high_status_bit = LH_DEFAULT;
      n.latch_low_status_bit = LL_DEFAULT;
      n.latch_peak_status_bit = PEAK_DEFAULT;
      if ((r.st == ST_EXIT) && tmr_done && !hw_req)
      begin
        n.ctrl_swrst = 1'b0;
        if (!r.sw_exit)
          n.phy_addr = r.strap_s2;
      end
    end
    else if (sw_req)
    begin
      n.ctrl_swrst = 1'b1;
    end
    else
    begin
      if (wr_ctrl)
        n.ctrl_pd = reg_wdata_i[CTRL_PD_BIT];
      if (pd_set)
      begin
        // only the latching bits lose their value on bit power-down;
        // an event in the same cycle still lands so it is never lost
        n.latch_high_status_bit = LH_DEFAULT || latch_high_event_i;
        n.latch_low_status_bit = LL_DEFAULT && latch_low_cond_i;
        n.latch_peak_status_bit = (peak_sample_i > PEAK_DEFAULT) ? peak_sample_i : PEAK_DEFAULT;
      end
      else
      begin
        // a new event in the read cycle survives the clear-on-read
        n.latch_high_status_bit = (r.latch_high_status_bit && !stat_rd) ||
                                  latch_high_event_i;
        n.latch_low_status_bit = (r.latch_low_status_bit || stat_rd) &&
                                 latch_low_cond_i;
        if (stat_rd || (peak_sample_i > r.latch_peak_status_bit))
          n.latch_peak_status_bit = peak_sample_i;
      end
    end

    // read data stand for one cycle only
    n.rdata = '0;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        REG_CTRL:
        begin
          n.rdata[CTRL_SWRST_BIT] = r.ctrl_swrst;
          n.rdata[CTRL_PD_BIT] = r.ctrl_pd;
        end
        REG_STATUS:
        begin
          n.rdata[STAT_LH_BIT] = r.latch_high_status_bit;
          n.rdata[STAT_LL_BIT] = r.latch_low_status_bit;
          n.rdata[STAT_PEAK_LSB +: PEAK_W] = r.latch_peak_status_bit;
        end
        REG_EXT_CTRL:
        begin
          n.rdata[EXT_ADDR_LSB +: ADDR_W] = r.phy_addr;
        end
        default:
        begin
          n.rdata = '0;
        end
      endcase
    end

    // MAC side: inputs isolated and outputs low until released
    n.core_tx = released ? mac_tx_i : '0;
    n.mac_rx = released ? core_rx_i : '0;
    n.line = core_line_i;
    n.line_oe = released;

    // MAC clocks restart only once recovery has settled
    if ((r.st == ST_RUN) && !pd)
    begin
      if (r.div_cnt == DIV_LAST)
      begin
        n.div_cnt = '0;
        n.mac_clk = !r.mac_clk;
      end
      else
        n.div_cnt = r.div_cnt + DIV_W'(1);
    end
    else
    begin
      n.div_cnt = '0;
      n.mac_clk = 1'b0;
    end
  end

  // power-on clears to constants; MAC outputs are low from the first instant
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= REGS_RESET;
    else
      r <= n;
  end

  assign reg_rdata_o = r.rdata;
  assign core_tx_o = r.core_tx;
  assign mac_rx_o = r.mac_rx;
  assign transmit_clock_out_o = r.mac_clk;
  assign receive_clock_out_o = r.mac_clk;
  assign line_tx_positive_o = r.line.pos;
  assign line_tx_negative_o = r.line.neg;
  assign line_tx_oe_o = r.line_oe;
  assign core_reset_o = in_reset;
  assign power_down_o = pd;
  assign mgmt_ready_o = mgmt_ready;
  assign clocks_valid_o = (r.st == ST_RUN);
endmodule

// File: tb/phy_rst_seq_checker.sv
// concurrent checks on the reset/power-down sequencer ports
// assumes one clock domain and rst_n_i as its asynchronous reset
`timescale 1ns/1ns
module phy_rst_seq_checker
  import phy_rst_pkg::*;
#(
  parameter int SETTLE_CYC = 20
)(
  input wire logic ref_clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic hw_reset_pin_n_i, // reset pin
  input wire logic [REG_ADDR_W-1:0] reg_addr_i, // address
  input wire logic [DATA_W-1:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write
  input wire logic reg_rd_i, // read
  input wire logic [DATA_W-1:0] reg_rdata_o, // read data
  input wire mac_tx_t core_tx_o, // gated tx
  input wire mac_rx_t mac_rx_o, // gated rx
  input wire logic transmit_clock_out_o, // tx clock
  input wire logic receive_clock_out_o, // rx clock
  input wire logic line_tx_oe_o, // line enable
  input wire logic core_reset_o, // core reset
  input wire logic power_down_o, // power-down
  input wire logic mgmt_ready_o, // mgmt ready
  input wire logic clocks_valid_o // clocks valid
);
  localparam int REL_MAX = 80;
  logic up_once;
  int settle_cnt;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // the power-on hold also keeps the pin ignored, so pin exits count only once up
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i) up_once <= 1'b0;
    else if (mgmt_ready_o) up_once <= 1'b1;
  end

  // length of the window in which management is up but clocks are not yet valid
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i) settle_cnt <= 0;
    else if (!mgmt_ready_o || clocks_valid_o) settle_cnt <= 0;
    else settle_cnt <= settle_cnt + 1;
  end

  sequence sw_req;
    mgmt_ready_o && hw_reset_pin_n_i && reg_wr_i && reg_addr_i == REG_CTRL
      && reg_wdata_i[CTRL_SWRST_BIT] && !reg_wdata_i[CTRL_PD_BIT];
  endsequence
  sequence hw_exit;
    up_once && core_reset_o && power_down_o && $rose(hw_reset_pin_n_i);
  endsequence

  a_mac_zero: assert property (core_reset_o |=> mac_rx_o == '0 && core_tx_o == '0)
    else $error("mac side not idle in reset");
  a_line_off: assert property (power_down_o || core_reset_o |=> !line_tx_oe_o)
    else $error("line driven in power-down");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0)
    else $error("read data without read");
  a_pin_pd: assert property (!hw_reset_pin_n_i [*3] |-> power_down_o)
    else $error("pin low without power-down");
  a_sw_enter: assert property (sw_req |=> core_reset_o && !mgmt_ready_o)
    else $error("software reset not entered");
  a_sw_no_pd: assert property (sw_req |=> !power_down_o [*8])
    else $error("software reset entered power-down");
  a_sw_done: assert property (sw_req |=> core_reset_o [*8] ##[1:6] mgmt_ready_o)
    else $error("software reset did not complete");
  a_hw_exit: assert property (hw_exit |-> ##[1:16] mgmt_ready_o)
    else $error("hardware exit too slow");
  a_mac_release: assert property (hw_exit |-> ##[1:REL_MAX] line_tx_oe_o)
    else $error("line not released in time");
  a_valid_late: assert property ($rose(clocks_valid_o) |-> settle_cnt == SETTLE_CYC)
    else $error("clocks valid too early");
  a_clk_gated: assert property (!clocks_valid_o || power_down_o |=>
    !transmit_clock_out_o && !receive_clock_out_o)
    else $error("mac clocks running while gated");
endmodule

bind phy_reset_powerdown_seq phy_rst_seq_checker #(.SETTLE_CYC(SETTLE_CYC)) chk_i (
  .ref_clk_i, .rst_n_i, .hw_reset_pin_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .core_tx_o, .mac_rx_o, .transmit_clock_out_o,
  .receive_clock_out_o, .line_tx_oe_o, .core_reset_o, .power_down_o, .mgmt_ready_o,
  .clocks_valid_o
);

// File: tb/mac_sta_model.sv
// behavioural MAC transmit side facing the sequencer
// assumes clocks_valid_i comes from the sequencer
`timescale 1ns/1ns
module mac_sta_model
  import phy_rst_pkg::*;
(
  input wire logic ref_clk_i, // clock
  input wire logic clocks_valid_i, // data side usable
  output mac_tx_t mac_tx_o // MAC outputs
);
  mac_tx_t q = '0;
  assign mac_tx_o = q;
  // idle txd lines toggle so a stale value never looks like a held one
  always @(posedge ref_clk_i)
  begin
    q.txd <= clocks_valid_i ? q.txd + 4'h1 : ~q.txd;
    q.tx_en <= clocks_valid_i;
    q.tx_er <= 1'b0;
  end
endmodule

// File: tb/phy_reset_powerdown_seq_tb.sv
// self-checking bench for the reset/power-down sequencer
// assumes a shortened clock settle span
`timescale 1ns/1ns
module phy_reset_powerdown_seq_tb;
  import phy_rst_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n = 1'b0, pin_n = 1'b1, wr = 1'b0, rd = 1'b0, lh_ev = 1'b0, ll_cond = 1'b1;
  logic [4:0] strap = 5'h0a, addr = '0;
  logic [15:0] wdata = '0, rdata;
  mac_tx_t mac_tx, core_tx;
  mac_rx_t core_rx = '0, mac_rx;
  line_t core_line = '0;
  logic tclk, rclk, lpos, lneg, loe, creset, pd, ready, valid, lvl;
  int failures = 0, checks = 0, n;

  always #4 ref_clk_i = ~ref_clk_i;

  phy_reset_powerdown_seq #(.SETTLE_CYC(20)) phy_reset_powerdown_seq_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n), .hw_reset_pin_n_i(pin_n),
    .phy_addr_strap_i(strap), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .mac_tx_i(mac_tx), .core_tx_o(core_tx),
    .core_rx_i(core_rx), .mac_rx_o(mac_rx), .transmit_clock_out_o(tclk),
    .receive_clock_out_o(rclk), .core_line_i(core_line), .line_tx_positive_o(lpos),
    .line_tx_negative_o(lneg), .line_tx_oe_o(loe), .latch_high_event_i(lh_ev),
    .latch_low_cond_i(ll_cond), .peak_sample_i(8'h00), .core_reset_o(creset),
    .power_down_o(pd), .mgmt_ready_o(ready), .clocks_valid_o(valid)
  );
  mac_sta_model mac_sta_model_i (.ref_clk_i(ref_clk_i), .clocks_valid_i(valid),
    .mac_tx_o(mac_tx));

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [4:0] a, input logic [15:0] exp, input string name);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk(name, rdata, exp);
  endtask
  task wait_ready(output int k);
    k = 0;
    while (ready !== 1'b1 && k < 5000)
    begin
      @(posedge ref_clk_i);
      #1;
      k++;
    end
  endtask
  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    rst_n <= 1'b1;
    repeat (200) @(posedge ref_clk_i);
    pin_n <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    pin_n <= 1'b1;
    #1;
    chk("por power down", 16'(pd), 16'h0001);
    chk("por core reset", 16'(creset), 16'h0001);
    chk("por line enable", 16'(loe), 16'h0000);
    wait_ready(n);
    chk("por hold span", 16'(n > 2200), 16'h0001);
    chk("clocks early", 16'(valid), 16'h0000);
    rd_reg(REG_EXT_CTRL, 16'(5'h0a) << EXT_ADDR_LSB, "por address");
    rd_reg(REG_CTRL, 16'h0000, "ctrl after por");
    rd_reg(5'h05, 16'h0000, "unmapped read");
    rd_reg(REG_STATUS, 16'h0002, "status default");
    n = 0;
    while (valid !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    @(posedge ref_clk_i);
    core_rx <= '{4'h5, 1'b1, 1'b0};
    core_line <= '{1'b1, 1'b0};
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("mac rx data", 16'(mac_rx), 16'h0016);
    chk("line enable", 16'(loe), 16'h0001);
    chk("line pos", 16'(lpos), 16'h0001);
    chk("core tx enable", 16'(core_tx.tx_en), 16'h0001);
    chk("line neg", 16'(lneg), 16'h0000);
    // released clocks flip every second cycle, so two cycles apart they differ
    lvl = tclk;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("tx clock toggles", 16'(tclk), 16'(!lvl));
    chk("rx clock toggles", 16'(rclk), 16'(!lvl));
    $display("test por done");

    @(posedge ref_clk_i);
    lh_ev <= 1'b1;
    @(posedge ref_clk_i);
    lh_ev <= 1'b0;
    rd_reg(REG_STATUS, 16'h0003, "status latched");
    @(posedge ref_clk_i);
    lh_ev <= 1'b1;
    @(posedge ref_clk_i);
    lh_ev <= 1'b0;
    wr_reg(REG_CTRL, 16'h0800);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("bit power down", 16'(pd), 16'h0001);
    chk("bit line enable", 16'(loe), 16'h0000);
    chk("bit mac rx", 16'(mac_rx), 16'h0000);
    rd_reg(REG_CTRL, 16'h0800, "ctrl kept");
    rd_reg(REG_STATUS, 16'h0002, "status reinit");
    wr_reg(REG_CTRL, 16'h0000);
    $display("test power down done");

    @(posedge ref_clk_i);
    pin_n <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    pin_n <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    #1;
    chk("short pulse ready", 16'(ready), 16'h0001);
    chk("short pulse reset", 16'(creset), 16'h0000);
    $display("test short pulse done");

    @(posedge ref_clk_i);
    strap <= 5'h13;
    pin_n <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk("hw power down", 16'(pd), 16'h0001);
    chk("hw core reset", 16'(creset), 16'h0001);
    chk("hw mac rx", 16'(mac_rx), 16'h0000);
    chk("hw line enable", 16'(loe), 16'h0000);
    @(posedge ref_clk_i);
    pin_n <= 1'b1;
    #1;
    wait_ready(n);
    chk("hw exit span", 16'(n <= 16), 16'h0001);
    rd_reg(REG_EXT_CTRL, 16'(5'h13) << EXT_ADDR_LSB, "hw address");
    rd_reg(REG_CTRL, 16'h0000, "ctrl after hw");
    $display("test hardware reset done");

    @(posedge ref_clk_i);
    strap <= 5'h07;
    wr_reg(REG_CTRL, 16'h8000);
    #1;
    chk("sw core reset", 16'(creset), 16'h0001);
    chk("sw power down", 16'(pd), 16'h0000);
    wait_ready(n);
    chk("sw span", 16'(n == SW_RESET_CYC + EXIT_DWELL_CYC), 16'h0001);
    rd_reg(REG_CTRL, 16'h0000, "ctrl after sw");
    rd_reg(REG_EXT_CTRL, 16'(5'h13) << EXT_ADDR_LSB, "sw address");
    $display("test software reset done");
    stop_test;
  end

  // the whole sequence needs about 2600 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    failures++;
    $display("watchdog expired");
    stop_test;
  end
endmodule
